// *** fsw_pkg.sv ***
package fsw_pkg;

    // Command codes seen on the serial link
    localparam logic [7:0] OPC_WRITE_STATUS_ONE = 8'h01;
    localparam logic [7:0] OPC_WRITE_STATUS_TWO = 8'h31;
    localparam logic [7:0] OPC_RESET            = 8'hf0;
    localparam logic [7:0] RESET_CONFIRM        = 8'hd0;
    localparam logic [7:0] OPC_WRITE_ENABLE     = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE    = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS      = 8'h05;

    // Link framing
    localparam int         BYTE_BITS        = 8;
    localparam logic [2:0] BIT_CNT_RESET    = 3'h0;
    localparam logic [1:0] BYTE_CNT_RESET   = 2'h0;
    localparam logic [1:0] BYTES_OPCODE     = 2'h1;
    localparam logic [1:0] BYTES_WITH_DATA  = 2'h2;
    localparam logic [1:0] BYTES_WITH_CONF  = 2'h3;
    localparam logic [1:0] BYTE_IDX_OPCODE  = 2'h0;
    localparam logic [1:0] BYTE_IDX_DATA    = 2'h1;
    localparam logic [1:0] BYTE_IDX_CONF    = 2'h2;

    // First write data byte fields
    localparam int WS1_LOCK_POS    = 7;
    localparam int WS1_GLOBAL_HI   = 5;
    localparam int WS1_GLOBAL_LO   = 2;
    // Second write data byte fields
    localparam int WS2_RESET_EN_POS = 4;
    localparam int WS2_LOCK_EN_POS  = 3;

    // First status byte layout
    localparam int ST1_LOCK_POS  = 7;
    localparam int ST1_WPP_POS   = 4;
    localparam int ST1_WEL_POS   = 1;
    localparam int ST1_BUSY_POS  = 0;
    // Second status byte layout
    localparam int ST2_RESET_EN_POS = 4;
    localparam int ST2_LOCK_EN_POS  = 3;
    localparam int ST2_PS_POS       = 2;
    localparam int ST2_ES_POS       = 1;
    localparam int ST2_BUSY_POS     = 0;

    // Values after reset
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] GLOBAL_FIELD_RESET = 4'h0;

endpackage

// *** fsw_flash_status.sv ***
// Overview of operation
// - Program-suspended flag shows suspended sector
// - Erase-suspended flag shows suspended sector
// - Busy set during operation; status reread continually
// - Opcode 01h plus one byte; extras ignored
// - Byte one: lock bit 7, field 5..2
// - Valid write updates lock, clears enable latch
// - Global action from field and prior lock
// - Bad framing: lock kept, latch cleared
// - Write-protect pin blocks clearing the lock
// - Opcode 31h plus one byte; extras ignored
// - Byte two: reset enable 4, lockdown 3
// - Valid write updates enables; lockdown enable not while frozen
// - Bad framing: enables kept, latch cleared
// - Enables change only by second write; freeze clears lockdown
// - Reset ignores the write enable latch
// - Reset acts only when reset enabled
// - Reset is F0h then D0h; extras ignored
// - Valid reset aborts running program or erase
// - Reset clears latch, suspends; keeps the rest
// - Reset aborts suspended operation too
// - Incomplete or misaligned reset does nothing
// - Latch low refuses status write commands
// - After freeze, lockdown enable stays zero
module fsw_flash_status
(
    // System side
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    // Serial link
    input  wire logic                 SCK,
    input  wire logic                 CS_N,
    input  wire logic                 SI,
    input  wire logic                 WP_N,
    output logic                      SO,
    output logic                      SO_OE,
    // Array engine status and events
    input  wire logic                 ENGINE_BUSY,
    input  wire logic                 PROG_SUSPEND_SET,
    input  wire logic                 PROG_SUSPEND_CLR,
    input  wire logic                 ERASE_SUSPEND_SET,
    input  wire logic                 ERASE_SUSPEND_CLR,
    input  wire logic                 LOCKDOWN_FREEZE,
    // Commands to the engines
    output logic                      ENGINE_ABORT,
    output logic                      GLOBAL_STROBE,
    output logic [3:0]                GLOBAL_FIELD,
    output logic                      GLOBAL_PRIOR_LOCK,
    // Status bits
    output logic                      SECTOR_PROTECT_LOCK,
    output logic                      WRITE_ENABLE_LATCH,
    output logic                      RESET_ENABLE,
    output logic                      LOCKDOWN_ENABLE,
    output logic                      PROG_SUSPENDED,
    output logic                      ERASE_SUSPENDED
);
    import fsw_pkg::*;

    // ---------------- Link domain (SCK) ----------------
    logic       new_frame;
    // Power-up value only; the link side has no reset of its own
    logic       frame_tog = 1'b0;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] shift_in;
    logic [7:0] opcode;
    logic [7:0] data_byte;
    logic [2:0] cur_bits;
    logic [1:0] cur_bytes;
    logic [7:0] next_shift;
    logic [15:0] st_meta;
    logic [15:0] st_link;
    logic [7:0] shift_out;
    logic       out_sel;

    // Chip select high arms a fresh count; SCK is idle then
    always_ff @(posedge SCK or posedge CS_N)
    begin
        if (CS_N)
            new_frame <= 1'b1;
        else
            new_frame <= 1'b0;
    end

    // First rising edge of a frame restarts both counts
    always_comb
    begin
        cur_bits   = new_frame ? BIT_CNT_RESET : bit_cnt;
        cur_bytes  = new_frame ? BYTE_CNT_RESET : byte_cnt;
        next_shift = {shift_in[6:0], SI};
    end

    // Counts are kept after release so the system side can judge them
    always_ff @(posedge SCK)
    begin
        bit_cnt  <= cur_bits + 3'h1;
        shift_in <= next_shift;
        if (new_frame)
            frame_tog <= ~frame_tog;
        if (cur_bits == 3'h7)
        begin
            if (cur_bytes != BYTES_WITH_CONF)
                byte_cnt <= cur_bytes + 2'h1;
            else
                byte_cnt <= cur_bytes;
        end
        else
            byte_cnt <= cur_bytes;
    end

    // Later bytes fall away once the needed ones are held
    always_ff @(posedge SCK)
    begin
        if (cur_bits == 3'h7)
        begin
            case (cur_bytes)
                BYTE_IDX_OPCODE: opcode    <= next_shift;
                // The reset confirmation arrives in the data slot
                BYTE_IDX_DATA:   data_byte <= next_shift;
                default:         opcode    <= opcode;
            endcase
        end
    end

    // Status words reach the link through two flops
    logic [7:0] stat_one;
    logic [7:0] stat_two;
    always_ff @(posedge SCK)
    begin
        st_meta <= {stat_one, stat_two};
        st_link <= st_meta;
    end

    // Each byte boundary reloads fresh status, alternating the bytes
    always_ff @(negedge SCK or posedge CS_N)
    begin
        if (CS_N)
        begin
            SO        <= 1'b0;
            SO_OE     <= 1'b0;
            shift_out <= 8'h00;
            out_sel   <= 1'b0;
        end
        // Counts from the last frame are stale before the first rise
        else if (!new_frame && bit_cnt == BIT_CNT_RESET
                 && byte_cnt != BYTE_CNT_RESET
                 && opcode == OPC_READ_STATUS)
        begin
            SO        <= out_sel ? st_link[7] : st_link[15];
            shift_out <= out_sel ? {st_link[6:0], 1'b0}
                                 : {st_link[14:8], 1'b0};
            SO_OE     <= 1'b1;
            out_sel   <= ~out_sel;
        end
        else
        begin
            SO        <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

    // ---------------- System domain (CLK) ----------------
    // Decisions are taken once per frame, at chip select release
    logic cs_s1, cs_s2, cs_s3;
    logic tog_s1, tog_s2, tog_seen;
    logic wp_s1, wp_s2;
    logic frame_end;
    logic whole_bytes;
    logic opc_done;
    logic arg_done;
    logic busy;
    logic frozen;
    logic wsr1_go, wsr1_valid, wsr2_go, wsr2_valid, do_reset;
    logic lock_clear_blocked;

    // Release edge and frame toggle, each through two flops
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            cs_s1    <= 1'b1;
            cs_s2    <= 1'b1;
            cs_s3    <= 1'b1;
            tog_s1   <= 1'b0;
            tog_s2   <= 1'b0;
            tog_seen <= 1'b0;
            wp_s1    <= 1'b1;
            wp_s2    <= 1'b1;
        end
        else
        begin
            cs_s1  <= CS_N;
            cs_s2  <= cs_s1;
            cs_s3  <= cs_s2;
            tog_s1 <= frame_tog;
            tog_s2 <= tog_s1;
            wp_s1  <= WP_N;
            wp_s2  <= wp_s1;
            if (cs_s2 && !cs_s3)
                tog_seen <= tog_s2;
        end
    end

    // One opcode decode for both status writes and the reset
    function automatic logic op_is(input logic       done,
                                   input logic [7:0] seen,
                                   input logic [7:0] code);
        return done && seen == code;
    endfunction

    // Frame words are stable here: SCK has stopped before release
    always_comb
    begin
        frame_end   = cs_s2 && !cs_s3 && (tog_s2 != tog_seen);
        whole_bytes = (bit_cnt == BIT_CNT_RESET);
        opc_done    = (byte_cnt >= BYTES_OPCODE);
        arg_done    = (byte_cnt >= BYTES_WITH_DATA) && whole_bytes;
        lock_clear_blocked = !wp_s2 && SECTOR_PROTECT_LOCK
                             && !data_byte[WS1_LOCK_POS];
        wsr1_go    = frame_end
                     && op_is(opc_done, opcode, OPC_WRITE_STATUS_ONE)
                     && !busy && WRITE_ENABLE_LATCH;
        wsr1_valid = wsr1_go && arg_done && !lock_clear_blocked;
        wsr2_go    = frame_end
                     && op_is(opc_done, opcode, OPC_WRITE_STATUS_TWO)
                     && !busy && WRITE_ENABLE_LATCH;
        wsr2_valid = wsr2_go && arg_done;
        // Reset needs opcode and confirmation, both whole
        do_reset   = frame_end && op_is(opc_done, opcode, OPC_RESET)
                     && byte_cnt >= BYTES_WITH_DATA && whole_bytes
                     && data_byte == RESET_CONFIRM
                     && RESET_ENABLE;
    end

    // Engine shares this clock; one flop aligns it with frame_end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            busy <= 1'b0;
        else
            busy <= ENGINE_BUSY;
    end

    // A refused write still needs a whole opcode to drop the latch
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            WRITE_ENABLE_LATCH <= 1'b0;
        else if (wsr1_go || wsr2_go || do_reset)
            WRITE_ENABLE_LATCH <= 1'b0;
        else if (frame_end && opc_done && whole_bytes)
        begin
            if (opcode == OPC_WRITE_ENABLE)
                WRITE_ENABLE_LATCH <= 1'b1;
            else if (opcode == OPC_WRITE_DISABLE)
                WRITE_ENABLE_LATCH <= 1'b0;
        end
    end

    // Reset command leaves the lock and both enables alone
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            SECTOR_PROTECT_LOCK <= 1'b0;
        else if (wsr1_valid)
            SECTOR_PROTECT_LOCK <= data_byte[WS1_LOCK_POS];
    end

    // Global action is decided downstream from field and prior lock
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            GLOBAL_STROBE     <= 1'b0;
            GLOBAL_FIELD      <= GLOBAL_FIELD_RESET;
            GLOBAL_PRIOR_LOCK <= 1'b0;
        end
        else
        begin
            GLOBAL_STROBE <= wsr1_valid;
            if (wsr1_valid)
            begin
                GLOBAL_FIELD      <= data_byte[WS1_GLOBAL_HI:WS1_GLOBAL_LO];
                GLOBAL_PRIOR_LOCK <= SECTOR_PROTECT_LOCK;
            end
        end
    end

    // Freeze lasts until the next reset of the device
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            frozen <= 1'b0;
        else if (LOCKDOWN_FREEZE)
            frozen <= 1'b1;
    end

    // Freeze outranks any write of the lockdown enable
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            RESET_ENABLE    <= 1'b0;
            LOCKDOWN_ENABLE <= 1'b0;
        end
        else
        begin
            if (wsr2_valid)
                RESET_ENABLE <= data_byte[WS2_RESET_EN_POS];
            if (frozen || LOCKDOWN_FREEZE)
                LOCKDOWN_ENABLE <= 1'b0;
            else if (wsr2_valid)
                LOCKDOWN_ENABLE <= data_byte[WS2_LOCK_EN_POS];
        end
    end

    // Engine events win over a reset clear in the same cycle
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            PROG_SUSPENDED  <= 1'b0;
            ERASE_SUSPENDED <= 1'b0;
        end
        else
        begin
            if (PROG_SUSPEND_SET)
                PROG_SUSPENDED <= 1'b1;
            else if (PROG_SUSPEND_CLR || do_reset)
                PROG_SUSPENDED <= 1'b0;
            if (ERASE_SUSPEND_SET)
                ERASE_SUSPENDED <= 1'b1;
            else if (ERASE_SUSPEND_CLR || do_reset)
                ERASE_SUSPENDED <= 1'b0;
        end
    end

    // Abort covers running and suspended operations alike
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            ENGINE_ABORT <= 1'b0;
        else
            ENGINE_ABORT <= do_reset;
    end

    // Snapshot for the link side; each bit is a slow level
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            stat_one <= STATUS_RESET;
            stat_two <= STATUS_RESET;
        end
        else
        begin
            stat_one <= STATUS_RESET;
            stat_one[ST1_LOCK_POS] <= SECTOR_PROTECT_LOCK;
            stat_one[ST1_WPP_POS]  <= ~wp_s2;
            stat_one[ST1_WEL_POS]  <= WRITE_ENABLE_LATCH;
            stat_one[ST1_BUSY_POS] <= busy;
            stat_two <= STATUS_RESET;
            stat_two[ST2_RESET_EN_POS] <= RESET_ENABLE;
            stat_two[ST2_LOCK_EN_POS]  <= LOCKDOWN_ENABLE;
            stat_two[ST2_PS_POS]       <= PROG_SUSPENDED;
            stat_two[ST2_ES_POS]       <= ERASE_SUSPENDED;
            stat_two[ST2_BUSY_POS]     <= busy;
        end
    end

endmodule

// *** fsw_flash_status_chk.sv ***
module fsw_chk
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Watched ports
    input wire logic WP_N,
    input wire logic PROG_SUSPEND_SET,
    input wire logic ERASE_SUSPEND_SET,
    input wire logic LOCKDOWN_FREEZE,
    input wire logic ENGINE_ABORT,
    input wire logic GLOBAL_STROBE,
    input wire logic SECTOR_PROTECT_LOCK,
    input wire logic WRITE_ENABLE_LATCH,
    input wire logic RESET_ENABLE,
    input wire logic LOCKDOWN_ENABLE,
    input wire logic PROG_SUSPENDED,
    input wire logic ERASE_SUSPENDED
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_abort_enabled: assert property (
        ENGINE_ABORT |-> RESET_ENABLE)
        else $error("abort without reset enable");
    a_abort_clears: assert property (
        ENGINE_ABORT |-> !WRITE_ENABLE_LATCH)
        else $error("abort left write latch set");
    a_abort_keeps: assert property (
        ENGINE_ABORT |-> SECTOR_PROTECT_LOCK == $past(SECTOR_PROTECT_LOCK, 2)
        && RESET_ENABLE == $past(RESET_ENABLE, 2))
        else $error("abort changed kept bits");
    a_strobe_latch: assert property (
        GLOBAL_STROBE |-> !WRITE_ENABLE_LATCH && $past(WRITE_ENABLE_LATCH, 2))
        else $error("strobe without latch handling");
    a_lock_rise: assert property (
        $rose(SECTOR_PROTECT_LOCK) |-> GLOBAL_STROBE ##1 !GLOBAL_STROBE)
        else $error("lock rose without one strobe");
    a_lock_guard: assert property (
        $fell(SECTOR_PROTECT_LOCK) |-> $past(WP_N, 3))
        else $error("lock cleared while protected");
    a_prog_susp: assert property (
        PROG_SUSPEND_SET |=> PROG_SUSPENDED)
        else $error("program suspend not shown");
    a_erase_susp: assert property (
        ERASE_SUSPEND_SET |=> ERASE_SUSPENDED)
        else $error("erase suspend not shown");
    a_freeze_holds: assert property (
        LOCKDOWN_FREEZE |=> !LOCKDOWN_ENABLE [*8])
        else $error("lockdown enable after freeze");
endmodule

bind fsw_flash_status fsw_chk chk_u
(
    .CLK, .RST_N, .WP_N, .PROG_SUSPEND_SET, .ERASE_SUSPEND_SET,
    .LOCKDOWN_FREEZE, .ENGINE_ABORT, .GLOBAL_STROBE, .SECTOR_PROTECT_LOCK,
    .WRITE_ENABLE_LATCH, .RESET_ENABLE, .LOCKDOWN_ENABLE,
    .PROG_SUSPENDED, .ERASE_SUSPENDED
);

// *** fsw_spi_host.sv ***
module fsw_spi_host
(
    // Serial link
    output logic SCK,
    output logic CS_N,
    output logic SI,
    // Returned data, sampled on the rising edge
    input  logic SO,
    input  logic SO_OE
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] rx = 32'h0;
    logic [31:0] oe = 32'h0;

    initial
    begin
        SCK = 1'b0;
        CS_N = 1'b1;
        SI = 1'b1;
    end

    // Mode 0, MSB first; clock stands still outside frames
    task automatic frame(input logic [31:0] d, input int n);
        CS_N = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            SI = d[31 - i];
            #15 SCK = 1'b1;
            rx = {rx[30:0], SO};
            oe = {oe[30:0], SO_OE};
            #15 SCK = 1'b0;
        end
        #15 CS_N = 1'b1;
        // Released line must not look like a held bit
        SI = ~SI;
    endtask
endmodule

// *** test_flash_status_write_and_reset.sv ***
module test_flash_status_write_and_reset;
    timeunit 1ns;
    timeprecision 100ps;
    import fsw_pkg::*;

    logic       CLK = 1'b0;
    logic       RST_N = 1'b0;
    logic       WP_N = 1'b1;
    logic       ENGINE_BUSY = 1'b0;
    logic [4:0] ev = 5'h00;
    logic       SCK, CS_N, SI, ENGINE_ABORT, GLOBAL_STROBE, GLOBAL_PRIOR_LOCK;
    logic       SO, SO_OE;
    logic [3:0] GLOBAL_FIELD;
    logic [3:0] ef = 4'h0;
    logic [5:0] st;
    logic [5:0] e = 6'h00;
    logic       epl = 1'b0;
    logic       frz = 1'b0;
    int         failures = 0, n_compared = 0;
    int         n_abort = 0, n_strobe = 0, na = 0, ns = 0;

    fsw_spi_host host_u
    (
        .SCK, .CS_N, .SI, .SO, .SO_OE
    );
    fsw_flash_status dut_u
    (
        .CLK, .RST_N, .SCK, .CS_N, .SI, .WP_N, .SO, .SO_OE, .ENGINE_BUSY,
        .PROG_SUSPEND_SET(ev[4]), .PROG_SUSPEND_CLR(ev[3]),
        .ERASE_SUSPEND_SET(ev[2]), .ERASE_SUSPEND_CLR(ev[1]),
        .LOCKDOWN_FREEZE(ev[0]), .ENGINE_ABORT, .GLOBAL_STROBE,
        .GLOBAL_FIELD, .GLOBAL_PRIOR_LOCK,
        .SECTOR_PROTECT_LOCK(st[5]), .WRITE_ENABLE_LATCH(st[4]),
        .RESET_ENABLE(st[3]), .LOCKDOWN_ENABLE(st[2]),
        .PROG_SUSPENDED(st[1]), .ERASE_SUSPENDED(st[0])
    );

    always #4 CLK = ~CLK;

    always @(posedge CLK)
    begin
        n_abort <= n_abort + int'(ENGINE_ABORT === 1'b1);
        n_strobe <= n_strobe + int'(GLOBAL_STROBE === 1'b1);
    end

    task automatic complete_run();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Whole opcode and data byte, ended on a byte edge
    function automatic logic whole(input int n);
        return n >= 16 && n % 8 == 0;
    endfunction

    task automatic cmd(input logic [31:0] d, input int n);
        host_u.frame(d, n);
        // Sync and decode finish well inside this gap
        repeat (10) @(negedge CLK);
    endtask

    task automatic wren();
        cmd({OPC_WRITE_ENABLE, 24'h0}, 8);
        e[4] = 1'b1;
    endtask

    task automatic wr(input logic [7:0] op, input logic [7:0] v, input int n);
        logic ok;
        ok = e[4] && !ENGINE_BUSY && whole(n);
        if (op == OPC_WRITE_STATUS_ONE && !WP_N && e[5] && !v[7])
            ok = 1'b0;
        if (ok && op == OPC_WRITE_STATUS_ONE)
        begin
            ns++;
            epl = e[5];
            ef = v[5:2];
            e[5] = v[7];
        end
        else if (ok)
        begin
            e[3] = v[4];
            e[2] = v[3] && !frz;
        end
        if (!ENGINE_BUSY)
            e[4] = 1'b0;
        cmd({op, v, ~v, 8'h00}, n);
        chk(32'(st), 32'(e));
        chk(32'(n_strobe), 32'(ns));
        chk(32'({GLOBAL_FIELD, GLOBAL_PRIOR_LOCK}), 32'({ef, epl}));
    endtask

    task automatic rs(input logic [7:0] c, input int n);
        if (e[3] && whole(n) && c == RESET_CONFIRM)
        begin
            na++;
            e[4] = 1'b0;
            e[1:0] = 2'h0;
        end
        cmd({OPC_RESET, c, ~c, 8'h00}, n);
        chk(32'(st), 32'(e));
        chk(32'(n_abort), 32'(na));
    endtask

    // Status bytes one and two as the link should return them
    function automatic logic [15:0] stat_exp();
        logic [7:0] a;
        logic [7:0] b;
        a = STATUS_RESET;
        b = STATUS_RESET;
        a[ST1_LOCK_POS] = e[5];
        a[ST1_WPP_POS] = !WP_N;
        a[ST1_WEL_POS] = e[4];
        a[ST1_BUSY_POS] = ENGINE_BUSY;
        b[ST2_RESET_EN_POS] = e[3];
        b[ST2_LOCK_EN_POS] = e[2];
        b[ST2_PS_POS] = e[1];
        b[ST2_ES_POS] = e[0];
        b[ST2_BUSY_POS] = ENGINE_BUSY;
        return {a, b};
    endfunction

    // Status read: opcode, then byte one and byte two
    task automatic rd();
        cmd({OPC_READ_STATUS, 24'h0}, 24);
        chk(32'(host_u.rx[15:0]), 32'(stat_exp()));
        chk(32'({host_u.oe[23:0], SO_OE}), 32'h0001fffe);
    endtask

    task automatic pulse(input int b);
        ev[b] = 1'b1;
        @(negedge CLK);
        ev[b] = 1'b0;
        repeat (2) @(negedge CLK);
    endtask

    initial
    begin
        #200us;
        failures++;
        complete_run();
    end

    initial
    begin
        void'($urandom(32'h2537));
        repeat (5) @(negedge CLK);
        RST_N = 1'b1;
        repeat (3) @(negedge CLK);
        chk(32'(st), 32'h0);
        wr(OPC_WRITE_STATUS_ONE, 8'h80, 16);
        for (int i = 0; i < 8; i++)
        begin
            wren();
            wr(i[0] ? OPC_WRITE_STATUS_ONE : OPC_WRITE_STATUS_TWO,
               8'($urandom), 16 + 8 * i[1]);
        end
        rd();
        wren();
        cmd({OPC_WRITE_DISABLE, 24'h0}, 8);
        e[4] = 1'b0;
        chk(32'(st), 32'(e));
        wr(OPC_WRITE_STATUS_TWO, 8'h18, 16);
        $display("done: random writes");
        wren();
        wr(OPC_WRITE_STATUS_ONE, 8'h80, 16);
        for (int n = 12; n < 24; n += 5)
        begin
            wren();
            wr(OPC_WRITE_STATUS_ONE, 8'h00, n);
            wren();
            wr(OPC_WRITE_STATUS_TWO, {3'h0, ~e[3:2], 3'h0}, n);
        end
        $display("done: framing");
        WP_N = 1'b0;
        wren();
        wr(OPC_WRITE_STATUS_ONE, 8'h00, 16);
        rd();
        WP_N = 1'b1;
        wren();
        wr(OPC_WRITE_STATUS_ONE, 8'h00, 16);
        WP_N = 1'b0;
        wren();
        wr(OPC_WRITE_STATUS_ONE, 8'h80, 16);
        WP_N = 1'b1;
        $display("done: protect pin");
        wren();
        wr(OPC_WRITE_STATUS_TWO, 8'h10, 16);
        pulse(4);
        pulse(2);
        chk(32'(st[1:0]), 32'h3);
        pulse(3);
        pulse(1);
        chk(32'(st[1:0]), 32'h0);
        pulse(4);
        pulse(2);
        e[1:0] = 2'h3;
        wren();
        ENGINE_BUSY = 1'b1;
        wr(OPC_WRITE_STATUS_TWO, 8'h00, 16);
        rs(8'hd1, 16);
        rs(RESET_CONFIRM, 8);
        rs(RESET_CONFIRM, 20);
        rs(RESET_CONFIRM, 24);
        rs(RESET_CONFIRM, 16);
        rd();
        ENGINE_BUSY = 1'b0;
        wren();
        wr(OPC_WRITE_STATUS_TWO, 8'h08, 16);
        rs(RESET_CONFIRM, 16);
        pulse(0);
        frz = 1'b1;
        e[2] = 1'b0;
        chk(32'(st), 32'(e));
        wren();
        wr(OPC_WRITE_STATUS_TWO, 8'h18, 16);
        $display("done: reset and freeze");
        complete_run();
    end
endmodule
